//--- src/tssp_defs.vh
// constants for the three-wire serial port block
`ifndef TSSP_DEFS_VH
`define TSSP_DEFS_VH
`define TSSP_ADDR_W        3
`define TSSP_ADDR_CTRL1    3'h0
`define TSSP_ADDR_CTRL2    3'h1
`define TSSP_ADDR_LOW      3'h2
`define TSSP_ADDR_HIGH     3'h3
`define TSSP_ADDR_PAR      3'h4
`define TSSP_ADDR_NOPD     3'h5
`define TSSP_ADDR_ODSEL    3'h6
`define TSSP_ADDR_STAT     3'h7
`define TSSP_C1_ORDER      0
`define TSSP_C1_EDGE       1
`define TSSP_C1_CKLO       2
`define TSSP_C1_CKHI       3
`define TSSP_C2_OM0        0
`define TSSP_C2_OM1        1
`define TSSP_C2_STATUS     2
`define TSSP_C2_RUN        3
`define TSSP_RST_NIBBLE    4'h0
`define TSSP_OM_TRI        2'h0
`define TSSP_OM_SYNC       2'h1
`define TSSP_OM_DIRECT     2'h2
`define TSSP_OM_PAR        2'h3
`define TSSP_CK_SLAVE      2'h0
`define TSSP_CK_DIV4       2'h1
`define TSSP_CK_DIV2       2'h2
`define TSSP_CK_DIV1       2'h3
`define TSSP_SHIFTS        4'h8
`endif

//--- src/tssp_sync.v
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module tssp_sync #(
    parameter W = 4
) (
    input  wire         core_clk,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta;
    always @(posedge core_clk) begin
        if (rst) begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // tssp_sync

//--- src/tssp_prescale.v
// prescaler giving one-cycle enables at clk/4, clk/2 and clk
`timescale 1ns/1ps
`include "tssp_defs.vh"
module tssp_prescale (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       run,
    input  wire [1:0] sel,
    output reg        tick
);
    reg [1:0] cnt;
    always @(posedge core_clk) begin
        if (rst || !run) begin
            cnt  <= 2'h0;
            tick <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            case (sel)
                `TSSP_CK_DIV4: tick <= (cnt == 2'h3);
                `TSSP_CK_DIV2: tick <= cnt[0];
                `TSSP_CK_DIV1: tick <= 1'b1;
                default:       tick <= 1'b0;
            endcase
        end
    end
endmodule // tssp_prescale

//--- src/tssp_port.v
// three-wire serial port with parallel port mode and pin pull control
//
// Function
// - shift input bits into two readable nibbles
// - send loaded bits while receiving simultaneously
// - master clock from selectable prescaler tap
// - software picks edge, bit order, direct output
// - ready/select pin: ready or chip select
// - data out driven, data in input, clock per mode
// - mode three: four-bit parallel output
// - parallel data read returns pin levels
// - mode zero: all drivers off
// - pin levels readable in every mode
// - pull-down: option, not disabled, not open drain
// - pull-up: option, open drain, tristate or one
// - open drain drives zero only
// - reset: slave, cleared, lsb, negedge, tristate
// - run set: exactly eight shifts
// - after eighth shift: request, clear run
// - clock select: slave, div4, div2, undivided
// - output modes: resync posedge or direct
// - request set on last shift edge, cleared by any control two write
// - slave: eight edges after run, ready=run|status
`timescale 1ns/1ps
`include "tssp_defs.vh"
module tssp_port #(
    parameter PULLUP_OPTION   = 4'hf,
    parameter PULLDOWN_OPTION = 4'hf
) (
    input  wire                    core_clk,
    input  wire                    rst,
    input  wire [`TSSP_ADDR_W-1:0] addr,
    input  wire [3:0]              wdata,
    input  wire                    wr,
    input  wire                    rd,
    output reg  [3:0]              rdata,
    input  wire [3:0]              serial_port_pins_in,
    output reg  [3:0]              serial_port_pins_out,
    output reg  [3:0]              serial_port_pins_oe,
    output reg  [3:0]              pullup_en,
    output reg  [3:0]              pulldown_en,
    output reg                     serial_done_request
);
    reg [3:0] serial_control_one;
    reg [1:0] output_mode_select;
    reg       run;
    reg       status;
    reg [7:0] shreg;
    reg [3:0] parallel_out_data;
    reg [3:0] pulldown_disable;
    reg [3:0] open_drain_select;
    reg [3:0] shift_cnt;
    reg       serial_out_pin_bit;
    reg       clk_int;
    reg       clk_prev;
    reg [7:0] rx_sh;
    reg [1:0] ev_dly;
    wire [3:0] pins_s;
    wire       tick;
    wire [1:0] ck_sel;
    wire       master;
    wire       edge_pos;
    wire       msb_first;
    wire       sclk;
    wire       rise;
    wire       fall;
    wire       shift_ev;
    wire       last_shift;
    wire       run_wr;
    wire       serial_on;
    wire       first_bit;
    wire       in_ev;
    reg  [3:0] next_out;
    reg  [3:0] next_oe;
    reg  [3:0] drive_val;
    reg  [3:0] drive_en;
    integer    i;

    assign ck_sel    = serial_control_one[`TSSP_C1_CKHI:`TSSP_C1_CKLO];
    assign master    = (ck_sel != `TSSP_CK_SLAVE);
    assign edge_pos  = serial_control_one[`TSSP_C1_EDGE];
    assign msb_first = serial_control_one[`TSSP_C1_ORDER];
    assign serial_on = (output_mode_select == `TSSP_OM_SYNC)
                    || (output_mode_select == `TSSP_OM_DIRECT);
    assign run_wr    = wr && (addr == `TSSP_ADDR_CTRL2);

    tssp_sync #(
        .W (4)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .d        (serial_port_pins_in),
        .q        (pins_s)
    );

    tssp_prescale u_presc (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (run && master),
        .sel      (ck_sel),
        .tick     (tick)
    );

    // internal shift clock toggles on each tick while running
    always @(posedge core_clk) begin
        if (rst || !run || !master) begin
            clk_int <= 1'b0;
        end else if (tick) begin
            clk_int <= ~clk_int;
        end
    end

    // slave clock from the synchronised pin, ignored unless running
    assign sclk = master ? clk_int : pins_s[3];
    always @(posedge core_clk) begin
        if (rst) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= sclk;
        end
    end
    assign rise       = run && sclk && !clk_prev;
    assign fall       = run && !sclk && clk_prev;
    assign shift_ev   = edge_pos ? rise : fall;
    assign last_shift = shift_ev && (shift_cnt == `TSSP_SHIFTS - 4'h1);
    assign first_bit  = msb_first ? shreg[7] : shreg[0];
    // master: the data pin answers our own clock edge, which reaches
    // the pin a cycle late and comes back through the synchroniser
    assign in_ev      = master ? ev_dly[1] : shift_ev;

    // control, data and shift register
    always @(posedge core_clk) begin
        if (rst) begin
            serial_control_one <= `TSSP_RST_NIBBLE;
            output_mode_select <= `TSSP_OM_TRI;
            run                <= 1'b0;
            status             <= 1'b0;
            shreg              <= 8'h00;
            rx_sh              <= 8'h00;
            ev_dly             <= 2'h0;
            parallel_out_data  <= `TSSP_RST_NIBBLE;
            pulldown_disable   <= `TSSP_RST_NIBBLE;
            open_drain_select  <= `TSSP_RST_NIBBLE;
            shift_cnt          <= 4'h0;
            serial_done_request <= 1'b0;
        end else begin
            if (wr) begin
                case (addr)
                    `TSSP_ADDR_CTRL1: serial_control_one <= wdata;
                    `TSSP_ADDR_CTRL2: begin
                        output_mode_select <= wdata[1:0];
                        status <= wdata[`TSSP_C2_STATUS];
                        run    <= wdata[`TSSP_C2_RUN];
                    end
                    `TSSP_ADDR_LOW: begin
                        if (!run) begin
                            shreg[3:0] <= wdata;
                            rx_sh[3:0] <= wdata;
                        end
                    end
                    `TSSP_ADDR_HIGH: begin
                        if (!run) begin
                            shreg[7:4] <= wdata;
                            rx_sh[7:4] <= wdata;
                        end
                    end
                    `TSSP_ADDR_PAR:   parallel_out_data <= wdata;
                    `TSSP_ADDR_NOPD:  pulldown_disable  <= wdata;
                    `TSSP_ADDR_ODSEL: open_drain_select <= wdata;
                    default: ;
                endcase
            end
            if (run_wr) begin
                shift_cnt <= 4'h0;
            end
            // shifting overrides a concurrent write while running
            if (shift_ev) begin
                if (msb_first) begin
                    shreg <= {shreg[6:0], 1'b0};
                end else begin
                    shreg <= {1'b0, shreg[7:1]};
                end
                shift_cnt <= shift_cnt + 4'h1;
                if (last_shift) begin
                    run       <= 1'b0;
                    shift_cnt <= 4'h0;
                end
            end
            // received bits enter their own register at the sample point
            ev_dly <= {ev_dly[0], shift_ev};
            if (in_ev) begin
                if (msb_first) begin
                    rx_sh <= {rx_sh[6:0], pins_s[0]};
                end else begin
                    rx_sh <= {pins_s[0], rx_sh[7:1]};
                end
            end
            // set wins over the clearing write
            if (last_shift && !(master && edge_pos)) begin
                serial_done_request <= 1'b1;
            end else if (rise && last_shift) begin
                serial_done_request <= 1'b1;
            end else if (run_wr) begin
                serial_done_request <= 1'b0;
            end
        end
    end

    // serial output bit: direct or resynchronised on rising edge
    always @(posedge core_clk) begin
        if (rst) begin
            serial_out_pin_bit <= 1'b0;
        end else if (output_mode_select == `TSSP_OM_DIRECT) begin
            serial_out_pin_bit <= first_bit;
        end else if (rise || !run) begin
            serial_out_pin_bit <= first_bit;
        end
    end

    // pin driver selection
    always @* begin
        drive_val = 4'h0;
        drive_en  = 4'h0;
        case (output_mode_select)
            `TSSP_OM_PAR: begin
                drive_val = parallel_out_data;
                drive_en  = 4'hf;
            end
            `TSSP_OM_SYNC, `TSSP_OM_DIRECT: begin
                drive_val[2] = serial_out_pin_bit;
                drive_en[2]  = 1'b1;
                drive_val[1] = run | status;
                drive_en[1]  = 1'b1;
                drive_val[3] = clk_int;
                drive_en[3]  = master;
            end
            default: begin
                drive_val = 4'h0;
                drive_en  = 4'h0;
            end
        endcase
        for (i = 0; i < 4; i = i + 1) begin
            // open drain releases the pin for a one
            next_out[i] = drive_val[i];
            next_oe[i]  = drive_en[i]
                       && !(open_drain_select[i] && drive_val[i]);
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            serial_port_pins_out <= 4'h0;
            serial_port_pins_oe  <= 4'h0;
            pullup_en            <= 4'h0;
            pulldown_en          <= 4'h0;
        end else begin
            serial_port_pins_out <= next_out;
            serial_port_pins_oe  <= next_oe;
            pulldown_en <= PULLDOWN_OPTION[3:0] & ~pulldown_disable
                         & ~open_drain_select;
            pullup_en <= PULLUP_OPTION[3:0] & open_drain_select
                       & (((output_mode_select == `TSSP_OM_TRI)
                           ? 4'hf : 4'h0)
                          | (drive_en & drive_val));
        end
    end

    // read data one cycle after the strobe
    always @(posedge core_clk) begin
        if (rst) begin
            rdata <= 4'h0;
        end else if (rd) begin
            case (addr)
                `TSSP_ADDR_CTRL1: rdata <= serial_control_one;
                `TSSP_ADDR_CTRL2: rdata <= {run, status,
                                            output_mode_select};
                `TSSP_ADDR_LOW:   rdata <= rx_sh[3:0];
                `TSSP_ADDR_HIGH:  rdata <= rx_sh[7:4];
                `TSSP_ADDR_PAR:   rdata <= pins_s;
                `TSSP_ADDR_NOPD:  rdata <= pulldown_disable;
                `TSSP_ADDR_ODSEL: rdata <= open_drain_select;
                `TSSP_ADDR_STAT:  rdata <= {3'h0, serial_done_request};
                default:          rdata <= 4'h0;
            endcase
        end else begin
            rdata <= 4'h0;
        end
    end
endmodule // tssp_port

//--- bench/tssp_partner.sv
// far-side serial device model with pin level resolution
`timescale 1ns/1ps
module tssp_partner (
    input  wire       core_clk,
    input  wire [3:0] dut_out,
    input  wire [3:0] dut_oe,
    input  wire [3:0] pu,
    input  wire [3:0] pd,
    input  wire       ext_clk,
    input  wire       pos,
    input  wire       msb,
    input  wire       load,
    input  wire [7:0] tx,
    output reg  [3:0] pins,
    output reg  [7:0] rx,
    output reg  [3:0] rises,
    output reg  [7:0] period
);
    reg       c3 = 1'b0;
    reg       dbit = 1'b0;
    reg       alt = 1'b0;
    reg [3:0] n = 4'h0;
    reg [7:0] cnt = 8'h0;
    wire [2:0] nx = n[2:0] + 3'h1;
    integer   i;
    // undriven lines 1 and 2 without a pull toggle every cycle
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            if (dut_oe[i]) pins[i] = dut_out[i];
            else if (i == 0) pins[i] = dbit;
            else if (i == 3) pins[i] = ext_clk;
            else if (pu[i]) pins[i] = 1'b1;
            else if (pd[i]) pins[i] = 1'b0;
            else pins[i] = alt;
        end
    end
    // at each active edge: take the bit, then present the next one
    always @(posedge core_clk) begin
        alt <= ~alt;
        c3 <= pins[3];
        cnt <= cnt + 8'h1;
        if (load) begin
            n <= 4'h0;
            rises <= 4'h0;
            dbit <= tx[msb ? 7 : 0];
        end else if (pins[3] != c3) begin
            if (pins[3]) begin
                rises <= rises + 4'h1;
                period <= cnt;
                cnt <= 8'h1;
            end
            if (pins[3] == pos) begin
                n <= n + 4'h1;
                rx[msb ? 7 - n[2:0] : n[2:0]] <= pins[2];
                dbit <= tx[msb ? 3'h7 - nx : nx];
            end
        end
    end
endmodule // tssp_partner

//--- bench/tssp_port_monitor.sv
// assertion checker for the three-wire serial port
`timescale 1ns/1ps
`include "tssp_defs.vh"
module tssp_port_monitor #(
    parameter PULLDOWN_OPTION = 4'hf
) (
    input wire                    core_clk,
    input wire                    rst,
    input wire [`TSSP_ADDR_W-1:0] addr,
    input wire [3:0]              wdata,
    input wire                    wr,
    input wire                    rd,
    input wire [3:0]              rdata,
    input wire [3:0]              serial_port_pins_out,
    input wire [3:0]              serial_port_pins_oe,
    input wire [3:0]              pullup_en,
    input wire [3:0]              pulldown_en,
    input wire                    serial_done_request
);
    reg  [3:0] nopd_q;
    reg  [3:0] od_q;
    wire       c2_wr = wr && addr == `TSSP_ADDR_CTRL2;
    always @(posedge core_clk) begin
        if (rst) begin
            nopd_q <= 4'h0;
            od_q <= 4'h0;
        end else if (wr && addr == `TSSP_ADDR_NOPD) begin
            nopd_q <= wdata;
        end else if (wr && addr == `TSSP_ADDR_ODSEL) begin
            od_q <= wdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_idle; !$past(rd) |-> rdata == 4'h0; endproperty
    a_idle: assert property (p_idle)
        else $error("read data not idle");
    property p_stat; rd && addr == `TSSP_ADDR_STAT
        |=> rdata == {3'h0, $past(serial_done_request)}; endproperty
    a_stat: assert property (p_stat)
        else $error("status read wrong");
    property p_clr; serial_done_request && c2_wr
        |=> !serial_done_request; endproperty
    a_clr: assert property (p_clr)
        else $error("request not cleared");
    property p_hold; serial_done_request && !c2_wr
        |=> serial_done_request; endproperty
    a_hold: assert property (p_hold)
        else $error("request dropped");
    property p_rst; $fell(rst) |-> serial_port_pins_oe == 4'h0
        && !serial_done_request && pullup_en == 4'h0; endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not idle after reset");
    property p_pd; !$past(rst) |-> pulldown_en ==
        (~($past(nopd_q) | $past(od_q)) & PULLDOWN_OPTION); endproperty
    a_pd: assert property (p_pd)
        else $error("pull-down enable wrong");
    property p_pu; !$past(rst)
        |-> (pullup_en & ~$past(od_q)) == 4'h0; endproperty
    a_pu: assert property (p_pu)
        else $error("pull-up without open drain");
    property p_od; (serial_port_pins_oe & serial_port_pins_out & od_q
        & $past(od_q) & $past(od_q, 2)) == 4'h0; endproperty
    a_od: assert property (p_od)
        else $error("open drain pin drove high");
endmodule // tssp_port_monitor
bind tssp_port tssp_port_monitor #(.PULLDOWN_OPTION(PULLDOWN_OPTION)) u_mon (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .serial_port_pins_out(serial_port_pins_out),
    .serial_port_pins_oe(serial_port_pins_oe),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .serial_done_request(serial_done_request)
);

//--- bench/tb_three_wire_serial_port.sv
// self-checking testbench for the three-wire serial port
`timescale 1ns/1ps
`include "tssp_defs.vh"
module tb_three_wire_serial_port;
    reg                    core_clk = 1'b0;
    reg                    rst = 1'b1;
    reg [`TSSP_ADDR_W-1:0] addr = 3'h0;
    reg [3:0]              wdata = 4'h0;
    reg                    wr = 1'b0;
    reg                    rd = 1'b0;
    reg                    ext_clk = 1'b0;
    reg                    pos = 1'b0;
    reg                    msb = 1'b0;
    reg                    load = 1'b0;
    reg [7:0]              tx = 8'h0;
    reg [7:0]              per [1:3];
    wire [3:0]             rdata, pins, p_out, p_oe, pu, pd, rises;
    wire [7:0]             rx, period;
    wire                   done;
    integer                n_errors = 0;
    integer                check_count = 0;
    integer                k;
    always #2 core_clk = ~core_clk;
    tssp_port dut_u (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .serial_port_pins_in(pins),
        .serial_port_pins_out(p_out), .serial_port_pins_oe(p_oe),
        .pullup_en(pu), .pulldown_en(pd), .serial_done_request(done)
    );
    tssp_partner far_u (
        .core_clk(core_clk), .dut_out(p_out), .dut_oe(p_oe), .pu(pu),
        .pd(pd), .ext_clk(ext_clk), .pos(pos), .msb(msb), .load(load),
        .tx(tx), .pins(pins), .rx(rx), .rises(rises), .period(period)
    );
    task chk(input string what, input [7:0] exp, input [7:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0s expected %h seen %h", what, exp, got);
        end
    endtask
    // returns once the write has reached the pins
    task wr_reg(input [2:0] a, input [3:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task rd_chk(input [2:0] a, input [3:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask
    task pulse(input integer cnt);
        repeat (cnt) begin
            repeat (4) @(posedge core_clk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_clk <= 1'b0;
        end
    endtask
    task reload;
        @(posedge core_clk);
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
    endtask
    task wait_done;
        integer j;
        for (j = 0; j < 2000 && done !== 1'b1; j = j + 1)
            @(posedge core_clk);
        #1;
        chk("done", 8'h1, done);
    endtask
    task end_of_test;
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors = n_errors + 1;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (k = 0; k < 8; k = k + 1) rd_chk(k[2:0], 4'h0);
        chk("oe", 4'h0, p_oe);
        wr_reg(`TSSP_ADDR_NOPD, 4'h3);
        chk("pd", 4'hc, pd);
        wr_reg(`TSSP_ADDR_NOPD, 4'h0);
        wr_reg(`TSSP_ADDR_PAR, 4'ha);
        wr_reg(`TSSP_ADDR_CTRL2, {2'h0, `TSSP_OM_PAR});
        chk("out", {p_oe, 4'ha}, {p_oe, p_out});
        chk("oe", 4'hf, p_oe);
        rd_chk(`TSSP_ADDR_PAR, 4'ha);
        wr_reg(`TSSP_ADDR_ODSEL, 4'hf);
        chk("oe", 4'h5, p_oe);
        chk("pu", 4'ha, pu);
        // released clock pin is held low by the partner's clock line
        rd_chk(`TSSP_ADDR_PAR, 4'h2);
        wr_reg(`TSSP_ADDR_CTRL2, 4'h0);
        chk("pu", 4'hf, pu);
        rd_chk(`TSSP_ADDR_PAR, 4'h6);
        wr_reg(`TSSP_ADDR_ODSEL, 4'h0);
        tx <= 8'h3a;
        for (k = 1; k < 4; k = k + 1) begin
            wr_reg(`TSSP_ADDR_CTRL1, {k[1:0], 2'h0});
            wr_reg(`TSSP_ADDR_LOW, 4'h5);
            wr_reg(`TSSP_ADDR_HIGH, 4'hc);
            reload;
            wr_reg(`TSSP_ADDR_CTRL2, 4'he);
            wait_done;
            per[k] = period;
            chk("rx", 8'hc5, rx);
            chk("rises", 8'h8, rises);
            chk("cs", 8'h1, p_out[1]);
            rd_chk(`TSSP_ADDR_LOW, 4'ha);
            rd_chk(`TSSP_ADDR_HIGH, 4'h3);
            rd_chk(`TSSP_ADDR_CTRL2, 4'h6);
            wr_reg(`TSSP_ADDR_CTRL2, 4'h0);
            rd_chk(`TSSP_ADDR_STAT, 4'h0);
        end
        chk("div", per[2] << 1, per[1]);
        chk("div", per[3] << 1, per[2]);
        wr_reg(`TSSP_ADDR_CTRL1, 4'h3);
        pos <= 1'b1;
        msb <= 1'b1;
        tx <= 8'h96;
        pulse(2);
        reload;
        wr_reg(`TSSP_ADDR_CTRL2, 4'ha);
        pulse(3);
        chk("rdy", 8'h3, {p_oe[1], p_out[1]});
        chk("clk", 8'h0, p_oe[3]);
        wr_reg(`TSSP_ADDR_LOW, 4'hf);
        pulse(5);
        wait_done;
        rd_chk(`TSSP_ADDR_LOW, 4'h6);
        rd_chk(`TSSP_ADDR_HIGH, 4'h9);
        chk("rdy", 8'h0, p_out[1]);
        end_of_test;
    end
endmodule // tb_three_wire_serial_port
